// *** hdl/fsk_pkg.sv ***
// constants, field layouts and carrier types of the serial command port
// assumes a 100 MHz system clock; command words are 16 bits, MSB first, except the fifo write: an 8-bit opcode then data bits
package fsk_pkg;

    // timing
    localparam int unsigned SYS_CLK_MHZ  = 100;
    localparam int unsigned POR_TIME_MS  = 100;
    localparam int unsigned POR_CYCLES   = POR_TIME_MS * 1000 * SYS_CLK_MHZ;

    // framing
    localparam logic [4:0]  OPC_LAST_BIT = 5'h07;   // count of the 8th bit of a frame
    localparam logic [4:0]  CMD_LAST_BIT = 5'h0F;   // count of the 16th bit of a frame

    // opcodes
    localparam logic [3:0]  OPC_CONFIG     = 4'h9;
    localparam logic [3:0]  OPC_FREQ       = 4'hA;
    localparam logic [7:0]  OPC_POWER      = 8'hC0;
    localparam logic [7:0]  OPC_FIFO_SET   = 8'hCE;
    localparam logic [7:0]  OPC_FIFO_WRITE = 8'hC6;

    // power-on values of the command registers
    localparam logic [15:0] POR_CONFIG     = 16'h9082;
    localparam logic [15:0] POR_FREQ       = 16'hAD57;
    localparam logic [15:0] POR_POWER      = 16'hC002;
    localparam logic [15:0] POR_FIFO_SET   = 16'hCE00;
    localparam logic [1:0]  POR_LOOP_BW    = 2'h2;

    // field positions
    localparam int unsigned FIFO_EN_POS    = 7;
    localparam int unsigned LOOP_BW_LSB    = 0;
    localparam logic [7:0]  POWER_KEEP     = 8'h3F;   // bits 7:6 of the power word are fixed
    localparam logic [7:0]  FIFO_SET_KEEP  = 8'hBF;   // bit 6 of the fifo setting is fixed

    // legal frequency word range
    localparam logic [11:0] FREQ_MIN       = 12'h060;
    localparam logic [11:0] FREQ_MAX       = 12'hF3F;

    // loop bandwidth in kHz and highest data rate in units of 100 bit/s
    localparam logic [7:0]  BW_KHZ_0       = 8'h0F;
    localparam logic [7:0]  BW_KHZ_1       = 8'h1E;
    localparam logic [7:0]  BW_KHZ_2       = 8'h3C;
    localparam logic [7:0]  BW_KHZ_3       = 8'h78;
    localparam logic [11:0] RATE_0         = 12'h0C0;
    localparam logic [11:0] RATE_1         = 12'h180;
    localparam logic [11:0] RATE_2         = 12'h280;
    localparam logic [11:0] RATE_3         = 12'h480;

    typedef struct packed {
        logic [15:0] cfg_word;
        logic [15:0] freq_word;
        logic [15:0] power_word;
        logic [15:0] fifo_set_word;
        logic [15:0] ext_feat_word;
    } fsk_cmd_regs_t;

    typedef struct packed {
        logic [1:0]  setting;
        logic [7:0]  bw_khz;
        logic [11:0] max_rate;
    } fsk_loop_bw_t;

    // decode of the two-bit loop bandwidth setting
    function automatic fsk_loop_bw_t fsk_loop_bw(input logic [1:0] sel);
        fsk_loop_bw_t d;
        d.setting = sel;
        case (sel)
            2'h0: begin
                d.bw_khz   = BW_KHZ_0;
                d.max_rate = RATE_0;
            end
            2'h1: begin
                d.bw_khz   = BW_KHZ_1;
                d.max_rate = RATE_1;
            end
            2'h2: begin
                d.bw_khz   = BW_KHZ_2;
                d.max_rate = RATE_2;
            end
            default: begin
                d.bw_khz   = BW_KHZ_3;
                d.max_rate = RATE_3;
            end
        endcase
        return d;
    endfunction : fsk_loop_bw

endpackage : fsk_pkg

// *** hdl/fsk_link_capture.sv ***
// serial clock domain: writes each data bit of a frame into place, first bit on top
// assumes select and data meet setup/hold to the serial clock; the reset
// comes from the system domain and only ever forces constants
`timescale 1ns/1ps
module fsk_link_capture
    import fsk_pkg::*;
#(
    parameter int unsigned FRAME_BITS = 72
) (
    input  wire logic                       spi_sck_i,
    input  wire logic                       link_rst_i,
    input  wire logic                       chip_select_low_i,
    input  wire logic                       spi_sdi_i,
    output logic [FRAME_BITS-1:0]           frame_o,
    output logic [$clog2(FRAME_BITS+1)-1:0] count_o
);

    localparam int unsigned CNT_W = $clog2(FRAME_BITS + 1);

    // the system side needs room for at least one whole fixed-length word
    if (FRAME_BITS <= int'(CMD_LAST_BIT)) begin : g_bad_frame
        $error("FRAME_BITS must hold at least one 16-bit word");
    end

    typedef struct packed {
        logic [FRAME_BITS-1:0] frame;
        logic [CNT_W-1:0]      count;
    } fsk_link_state_t;

    fsk_link_state_t state_reg;
    fsk_link_state_t state_next;
    logic            fresh_reg;   // select was high since the last serial edge

    // bits are kept by position so the frame can be read out whole once select rises;
    // the serial clock may outrun the system clock, so nothing crosses bit by bit
    always_comb begin
        logic [CNT_W-1:0] idx;
        idx        = CNT_W'(FRAME_BITS - 1) - state_reg.count;
        state_next = state_reg;
        if (!chip_select_low_i) begin
            if (fresh_reg) begin
                state_next.frame[FRAME_BITS-1] = spi_sdi_i;
                state_next.count               = CNT_W'(1);
            end else if (state_reg.count != CNT_W'(FRAME_BITS)) begin
                state_next.frame[idx] = spi_sdi_i;
                state_next.count      = state_reg.count + 1'b1;    // surplus bits dropped
            end
        end
    end

    // the serial clock is stopped while select is high, so this one flag is set by
    // select itself and lives outside the struct
    always_ff @(posedge spi_sck_i or posedge chip_select_low_i or posedge link_rst_i) begin
        if (chip_select_low_i || link_rst_i) begin
            fresh_reg <= 1'b1;
        end else begin
            fresh_reg <= 1'b0;
        end
    end

    // the serial clock stops between frames, so no edge is counted on outside them
    always_ff @(posedge spi_sck_i or posedge link_rst_i) begin
        if (link_rst_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign frame_o = state_reg.frame;
    assign count_o = state_reg.count;

endmodule : fsk_link_capture

// *** hdl/fsk_cmd_port.sv ***
// serial command receive port: assembles command words from the link and
// holds the command registers, the transmit bit fifo and the loop bandwidth
// assumes select stays high at least 40 ns between frames, since a frame is
// handed over whole once select is seen high, and that ce_i stays high then
//
// Behaviour
// - with select low, each rising serial clock edge shifts in one data bit.
// - select high resets the serial interface; next frame starts at bit zero.
// - words arrive most significant bit first, bit 15 leading a 16-bit word.
// - leading bits form the opcode; remaining bits are parameters or data.
// - reset loads every command register with its power-on value.
// - don't care parameter bits never change the block's behaviour.
// - two-bit loop bandwidth picks 15/30/60/120 kHz; reset picks 60 kHz.
// - during the power-on pulse no command is accepted.
// - fifo write opcode is followed by data bits, taken only with fifo enabled.
`timescale 1ns/1ps
module fsk_cmd_port
    import fsk_pkg::*;
#(
    parameter int unsigned POR_HOLD_CYCLES = POR_CYCLES,
    parameter int unsigned FIFO_BITS       = 64,
    parameter logic [7:0]  EXT_FEAT_OPCODE = 8'hE8  // arbitrary value
) (
    input  wire logic           sys_clk_i,
    input  wire logic           sys_rst_i,
    input  wire logic           ce_i,
    input  wire logic           spi_sck_i,
    input  wire logic           chip_select_low_i,
    input  wire logic           spi_sdi_i,
    input  wire logic           fifo_pop_i,
    output logic                ready_o,
    output logic                cmd_strobe_o,
    output fsk_cmd_regs_t       cmd_regs_o,
    output fsk_loop_bw_t        pll_loop_bandwidth_setting_o,
    output logic                fifo_bit_o,
    output logic [$clog2(FIFO_BITS+1)-1:0] fifo_count_o
);

    localparam int unsigned CNT_W = $clog2(FIFO_BITS + 1);
    localparam int unsigned IDX_W = $clog2(FIFO_BITS);

    // refuse settings the counters and decode cannot serve
    if (POR_HOLD_CYCLES < 1 || POR_HOLD_CYCLES >= 2**24) begin : g_bad_por
        $error("POR_HOLD_CYCLES must lie between 1 and 2**24-1");
    end
    if (FIFO_BITS < 8 || FIFO_BITS > 1024) begin : g_bad_fifo
        $error("FIFO_BITS must lie between 8 and 1024");
    end
    if (EXT_FEAT_OPCODE == OPC_POWER || EXT_FEAT_OPCODE == OPC_FIFO_SET
        || EXT_FEAT_OPCODE == OPC_FIFO_WRITE || EXT_FEAT_OPCODE[7:4] == OPC_CONFIG
        || EXT_FEAT_OPCODE[7:4] == OPC_FREQ) begin : g_bad_opc
        $error("EXT_FEAT_OPCODE collides with another opcode");
    end

    typedef struct packed {
        logic [1:0]           cs_sync;    // select, two-flop synchroniser
        logic                 cs_last;    // synchronised select one cycle ago
        logic                 frame_ok;   // frame began after the power-on pulse
        logic                 strobe;
        logic [23:0]          por_cnt;
        logic                 ready;
        fsk_cmd_regs_t        regs;
        logic [FIFO_BITS-1:0] fifo;
        logic [CNT_W-1:0]     fifo_cnt;
        logic                 fifo_bit;
        fsk_loop_bw_t         loop_bw;
    } fsk_port_state_t;

    localparam logic [15:0] POR_EXT_FEAT = {EXT_FEAT_OPCODE, 6'h00, POR_LOOP_BW};

    localparam fsk_port_state_t ST_RESET = '{
        cs_sync:   2'h3,
        cs_last:   1'b1,   // idle high, so reset shows no false frame end
        frame_ok:  1'b0,
        strobe:    1'b0,
        por_cnt:   24'h000000,
        ready:     1'b0,
        regs:      '{cfg_word:      POR_CONFIG,
                     freq_word:     POR_FREQ,
                     power_word:    POR_POWER,
                     fifo_set_word: POR_FIFO_SET,
                     ext_feat_word: POR_EXT_FEAT},
        fifo:      '0,
        fifo_cnt:  '0,
        fifo_bit:  1'b0,
        loop_bw:   fsk_loop_bw(POR_LOOP_BW)
    };

    fsk_port_state_t state_reg;
    fsk_port_state_t state_next;

    // a frame holds the fifo write opcode and at most a full fifo of data
    localparam int unsigned FRAME_BITS = FIFO_BITS + int'(OPC_LAST_BIT) + 1;
    localparam int unsigned LCNT_W     = $clog2(FRAME_BITS + 1);

    logic [FRAME_BITS-1:0] link_frame;
    logic [LCNT_W-1:0]     link_count;

    // serial clock domain front end
    fsk_link_capture #(
        .FRAME_BITS        (FRAME_BITS)
    ) u_link (
        .spi_sck_i         (spi_sck_i),
        .link_rst_i        (sys_rst_i),
        .chip_select_low_i (chip_select_low_i),
        .spi_sdi_i         (spi_sdi_i),
        .frame_o           (link_frame),
        .count_o           (link_count)
    );

    // next state: select crossing, power-on hold, fifo drain, frame decode
    always_comb begin
        logic              frame_end;
        logic              sel_high;
        logic [15:0]       word;
        logic [CNT_W-1:0]  cnt;
        logic [IDX_W-1:0]  wr_idx;
        logic [LCNT_W-1:0] data_bits;
        frame_end  = 1'b0;
        sel_high   = 1'b0;
        word       = 16'h0000;
        cnt        = '0;
        wr_idx     = '0;
        data_bits  = '0;
        state_next = state_reg;

        state_next.strobe  = 1'b0;
        state_next.cs_sync = {state_reg.cs_sync[0], chip_select_low_i};
        state_next.cs_last = state_reg.cs_sync[1];
        sel_high  = state_reg.cs_sync[1];
        frame_end = sel_high && !state_reg.cs_last;

        // power-on pulse: the port stays deaf until the count runs out
        if (!state_reg.ready) begin
            if (state_reg.por_cnt == 24'(POR_HOLD_CYCLES - 1)) begin
                state_next.ready = 1'b1;
            end else begin
                state_next.por_cnt = state_reg.por_cnt + 24'h000001;
            end
        end

        // transmit side drains the oldest bit first
        cnt = state_reg.fifo_cnt;
        if (fifo_pop_i && cnt != '0) begin
            state_next.fifo_bit = state_reg.fifo[FIFO_BITS-1];
            state_next.fifo     = state_reg.fifo << 1;
            cnt                 = cnt - 1'b1;
        end
        state_next.fifo_cnt = cnt;

        // a frame is read only once select is seen high: the serial clock has stopped
        // by then, so the captured bits and their count stand still while they cross
        if (frame_end && state_reg.frame_ok) begin
            word = link_frame[FRAME_BITS-1 -: 16];
            if (link_count > LCNT_W'(OPC_LAST_BIT) && word[15:8] == OPC_FIFO_WRITE) begin
                // any number of data bits; a full fifo drops the surplus
                data_bits = link_count - LCNT_W'(OPC_LAST_BIT) - 1'b1;
                if (state_reg.regs.fifo_set_word[FIFO_EN_POS]) begin
                    for (int j = 0; j < FIFO_BITS; j++) begin
                        if (LCNT_W'(j) < data_bits && cnt != CNT_W'(FIFO_BITS)) begin
                            wr_idx = IDX_W'(FIFO_BITS - 1) - IDX_W'(cnt);
                            state_next.fifo[wr_idx] = link_frame[FIFO_BITS-1-j];
                            cnt = cnt + 1'b1;
                        end
                    end
                    state_next.fifo_cnt = cnt;
                end
            end else if (link_count > LCNT_W'(CMD_LAST_BIT)) begin
                // fixed-length commands need all 16 bits; shorter frames are dropped
                // and bits past the 16th are ignored
                state_next.strobe = 1'b1;
                if (word[15:12] == OPC_CONFIG) begin
                    state_next.regs.cfg_word = word;
                end else if (word[15:12] == OPC_FREQ) begin
                    // an out-of-range frequency word keeps the old one
                    if (word[11:0] >= FREQ_MIN && word[11:0] <= FREQ_MAX) begin
                        state_next.regs.freq_word = word;
                    end
                end else if (word[15:8] == OPC_POWER) begin
                    state_next.regs.power_word =
                        {OPC_POWER, word[7:0] & POWER_KEEP};
                end else if (word[15:8] == OPC_FIFO_SET) begin
                    state_next.regs.fifo_set_word =
                        {OPC_FIFO_SET, word[7:0] & FIFO_SET_KEEP};
                    if (!word[FIFO_EN_POS]) begin
                        state_next.fifo_cnt = '0;  // disabling the fifo empties it
                        state_next.fifo     = '0;
                    end
                end else if (word[15:8] == EXT_FEAT_OPCODE) begin
                    // only the bandwidth field is kept; other bits are ignored
                    state_next.regs.ext_feat_word =
                        {EXT_FEAT_OPCODE, 6'h00, word[LOOP_BW_LSB+1:LOOP_BW_LSB]};
                end
            end
        end

        // select high: the next frame starts afresh and counts only after the hold
        if (sel_high) begin
            state_next.frame_ok = state_reg.ready;
        end

        state_next.loop_bw = fsk_loop_bw(
            state_next.regs.ext_feat_word[LOOP_BW_LSB+1:LOOP_BW_LSB]);
    end

    // one register for all state; ce_i low freezes it, reset loads power-on values
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state_reg <= ST_RESET;
        end else if (ce_i) begin
            state_reg <= state_next;
        end
    end

    assign ready_o                      = state_reg.ready;
    assign cmd_strobe_o                 = state_reg.strobe;
    assign cmd_regs_o                   = state_reg.regs;
    assign pll_loop_bandwidth_setting_o = state_reg.loop_bw;
    assign fifo_bit_o                   = state_reg.fifo_bit;
    assign fifo_count_o                 = state_reg.fifo_cnt;

endmodule : fsk_cmd_port

// *** bench/fsk_cmd_port_asserts.sv ***
// assertion checker for the serial command port, bound to its top module
// sees only the top ports; the hold count follows ce_i just as the port does
`timescale 1ns/1ps
module fsk_cmd_port_asserts
    import fsk_pkg::*;
#(
    parameter int unsigned POR_HOLD_CYCLES = 20,
    parameter int unsigned FIFO_BITS       = 64
) (
    input  wire logic    sys_clk_i,
    input  wire logic    sys_rst_i,
    input  wire logic    ce_i,
    input  wire logic    ready_o,
    input  wire logic    cmd_strobe_o,
    input  fsk_cmd_regs_t cmd_regs_o,
    input  fsk_loop_bw_t pll_loop_bandwidth_setting_o,
    input  wire logic [$clog2(FIFO_BITS+1)-1:0] fifo_count_o
);
    logic [31:0] por_cnt_reg;
    logic [31:0] por_cnt_next;

    // cycles since reset, saturating so a long run cannot wrap it
    always_comb begin
        por_cnt_next = por_cnt_reg;
        if (ce_i && por_cnt_reg != POR_HOLD_CYCLES) por_cnt_next = por_cnt_reg + 32'h1;
    end
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) por_cnt_reg <= 32'h0;
        else por_cnt_reg <= por_cnt_next;
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    a_ready_time: assert property (ready_o == (por_cnt_reg == POR_HOLD_CYCLES))
        else $error("ready flag out of step with hold count");
    a_early_quiet: assert property (!ready_o |-> !cmd_strobe_o)
        else $error("command taken during power-on hold");
    a_strobe_once: assert property (cmd_strobe_o |=> !cmd_strobe_o)
        else $error("command strobe longer than one cycle");
    a_regs_on_strobe: assert property (!cmd_strobe_o |-> $stable(cmd_regs_o))
        else $error("command register changed without a command");
    a_bw_follows: assert property (pll_loop_bandwidth_setting_o.setting
        == cmd_regs_o.ext_feat_word[1:0])
        else $error("loop bandwidth differs from stored setting");
    a_bw_khz: assert property (pll_loop_bandwidth_setting_o.bw_khz
        == (8'h0F << pll_loop_bandwidth_setting_o.setting))
        else $error("loop bandwidth value wrong");
    a_bw_rate: assert property (pll_loop_bandwidth_setting_o.max_rate
        == ((pll_loop_bandwidth_setting_o.setting == 2'h0) ? 12'h0C0 :
            (pll_loop_bandwidth_setting_o.setting == 2'h1) ? 12'h180 :
            (pll_loop_bandwidth_setting_o.setting == 2'h2) ? 12'h280 : 12'h480))
        else $error("highest data rate wrong");
    a_fixed_bits: assert property (cmd_regs_o.power_word[15:6] == 10'h300
        && cmd_regs_o.fifo_set_word[15:8] == 8'hCE && !cmd_regs_o.fifo_set_word[6])
        else $error("fixed bits of a command word altered");
    a_freq_legal: assert property (cmd_regs_o.freq_word[15:12] == 4'hA
        && cmd_regs_o.freq_word[11:0] inside {[12'h060:12'hF3F]})
        else $error("frequency word out of range");
    a_fifo_clear: assert property ($past(!cmd_regs_o.fifo_set_word[7])
        && !cmd_regs_o.fifo_set_word[7] |-> !(|fifo_count_o))
        else $error("fifo holds bits while disabled");
endmodule : fsk_cmd_port_asserts

bind fsk_cmd_port fsk_cmd_port_asserts #(
    .POR_HOLD_CYCLES(POR_HOLD_CYCLES),
    .FIFO_BITS      (FIFO_BITS)
) u_asserts (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
    .ready_o(ready_o), .cmd_strobe_o(cmd_strobe_o), .cmd_regs_o(cmd_regs_o),
    .pll_loop_bandwidth_setting_o(pll_loop_bandwidth_setting_o),
    .fifo_count_o(fifo_count_o)
);

// *** bench/fsk_spi_master.sv ***
// serial master model: drives select, serial clock and data into the port
// assumes the caller starts a frame only once the select gap has passed
`timescale 1ns/1ps
module fsk_spi_master (
    output logic spi_sck_o,
    output logic chip_select_low_o,
    output logic spi_sdi_o
);
    // serial clock stands still low between frames
    initial begin
        spi_sck_o = 1'b0;
        chip_select_low_o = 1'b1;
        spi_sdi_o = 1'b0;
    end

    // one frame of n bits, msb first, 12 ns serial clock period
    task automatic send(input logic [31:0] word, input int unsigned n);
        chip_select_low_o = 1'b0;
        #10;
        for (int i = int'(n) - 1; i >= 0; i--) begin
            spi_sdi_o = word[i];
            #6 spi_sck_o = 1'b1;
            #6 spi_sck_o = 1'b0;
        end
        #30 chip_select_low_o = 1'b1;
        spi_sdi_o = ~spi_sdi_o; // a released line must not show a stale bit
        #50;
    endtask : send
endmodule : fsk_spi_master

// *** bench/fsk_cmd_port_tb_top.sv ***
// self-checking bench for the serial command port
// frames come from the master model; ce_i drops once to show that it freezes the port
`timescale 1ns/1ps
module fsk_cmd_port_tb_top;
    import fsk_pkg::*;
    localparam int unsigned HOLD = 40;
    localparam logic [7:0] EXT_OPC = 8'hE8; // arbitrary value
    logic sys_clk, sys_rst, ce, spi_sck, chip_select_low, sdi, fifo_pop_i;
    logic ready_o, cmd_strobe_o, fifo_bit_o;
    logic [6:0] fifo_count;
    fsk_cmd_regs_t regs;
    fsk_loop_bw_t bw;
    int unsigned s;
    int bad_count = 0;
    int compares = 0;

    fsk_cmd_port #(.POR_HOLD_CYCLES(HOLD), .FIFO_BITS(64), .EXT_FEAT_OPCODE(EXT_OPC)) u_dut (
        .sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .ce_i(ce), .spi_sck_i(spi_sck),
        .chip_select_low_i(chip_select_low), .spi_sdi_i(sdi), .fifo_pop_i(fifo_pop_i),
        .ready_o(ready_o), .cmd_strobe_o(cmd_strobe_o), .cmd_regs_o(regs),
        .pll_loop_bandwidth_setting_o(bw), .fifo_bit_o(fifo_bit_o), .fifo_count_o(fifo_count));
    fsk_spi_master u_mst (.spi_sck_o(spi_sck), .chip_select_low_o(chip_select_low),
        .spi_sdi_o(sdi));

    task automatic check(input logic [79:0] got, input logic [79:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic wrap_up();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : wrap_up

    // one frame while counting strobes until the answer has settled
    task automatic frame(input logic [31:0] w, input int unsigned n, input int unsigned e);
        s = 0;
        fork
            u_mst.send(w, n);
            repeat (50) begin
                @(posedge sys_clk);
                #1;
                if (cmd_strobe_o === 1'b1) s++;
            end
        join
        check(80'(s), 80'(e));
    endtask : frame

    // command words and partial frames
    task automatic t_cmds();
        frame(32'h9123, 16, 1);
        check(80'(regs.cfg_word), 80'h9123);
        frame(32'h9ABC, 12, 0);
        check(80'(regs.cfg_word), 80'h9123);
        frame(32'h9456, 16, 1);
        check(80'(regs.cfg_word), 80'h9456);
        frame(32'hA05F, 16, 1);
        check(80'(regs.freq_word), 80'hAD57);
        frame(32'hAF3F, 16, 1);
        check(80'(regs.freq_word), 80'hAF3F);
        frame(32'hC0FF, 16, 1);
        check(80'(regs.power_word), 80'hC03F);
    endtask : t_cmds

    // every loop bandwidth code, don't care bits set to one
    task automatic t_bw();
        logic [11:0] rt [4] = '{12'h0C0, 12'h180, 12'h280, 12'h480};
        for (int i = 0; i < 4; i++) begin
            frame({16'h0, EXT_OPC, 6'h3F, 2'(i)}, 16, 1);
            check(80'(regs.ext_feat_word), 80'({EXT_OPC, 6'h00, 2'(i)}));
            check(80'(bw), 80'({2'(i), 8'h0F << i, rt[i]}));
        end
    endtask : t_bw

    // fifo write refused, then taken, drained in order and cleared
    task automatic t_fifo();
        logic [4:0] d = 5'b10110;
        frame(32'hC6A5, 16, 0);
        check(80'(fifo_count), 80'h0);
        frame(32'hCE80, 16, 1);
        frame({19'h0, 8'hC6, d}, 13, 0);
        check(80'(fifo_count), 80'h5);
        // clock enable low: a pop request must leave the fifo untouched
        ce = 1'b0;
        fifo_pop_i = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 ce = 1'b1;
        check(80'(fifo_count), 80'h5);
        // pop held high: one bit per edge, oldest first
        for (int i = 4; i >= 2; i--) begin
            @(posedge sys_clk);
            #1;
            check(80'(fifo_bit_o), 80'(d[i]));
        end
        fifo_pop_i = 1'b0;
        check(80'(fifo_count), 80'h2);
        frame(32'hCE00, 16, 1);
        check(80'(fifo_count), 80'h0);
    endtask : t_fifo

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // watchdog well beyond the fewer than a thousand cycles the tests take
    initial begin
        #100000;
        bad_count++;
        wrap_up();
    end

    initial begin
        sys_rst = 1'b1;
        ce = 1'b1;
        fifo_pop_i = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 sys_rst = 1'b0;
        frame(32'h9123, 16, 0);
        for (int i = 0; i < 100 && ready_o !== 1'b1; i++) @(posedge sys_clk);
        repeat (4) @(posedge sys_clk);
        #1;
        check(80'(ready_o), 80'h1);
        check(regs, {16'h9082, 16'hAD57, 16'hC002, 16'hCE00, EXT_OPC, 8'h02});
        check(80'(bw), 80'({2'h2, 8'h3C, 12'h280}));
        check(80'(fifo_count), 80'h0);
        t_cmds();
        t_bw();
        t_fifo();
        wrap_up();
    end
endmodule : fsk_cmd_port_tb_top
